/* File: logic/iopm_pkg.sv */
// Register map, reset values and bank layout of the I/O line controller.
// Assumes a plain strobe register port with byte addresses.
package iopm_pkg;

    localparam int ADDR_W = 8;
    localparam int NBANK  = 6;

    // Bank indices; each bank is a set/clear pair with a readable status
    localparam int B_PULLUP_OFF = 0;
    localparam int B_SECOND_SEL = 1;
    localparam int B_WRITE_MASK = 2;
    localparam int B_OUT_ENABLE = 3;
    localparam int B_CTRL_OWN   = 4;
    localparam int B_OUT_LEVEL  = 5;

    // Set offset, clear offset and status offset of each bank
    localparam logic [ADDR_W-1:0] SET_OFS [NBANK] = '{
        8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60};
    localparam logic [ADDR_W-1:0] CLR_OFS [NBANK] = '{
        8'h14, 8'h1C, 8'h34, 8'h44, 8'h54, 8'h64};
    localparam logic [ADDR_W-1:0] STAT_OFS [NBANK] = '{
        8'h18, 8'h24, 8'h38, 8'h48, 8'h58, 8'h68};

    // Direct write of the output level register and pin level status
    localparam logic [ADDR_W-1:0] OUT_LEVEL_WR_OFS = 8'h68;
    localparam logic [ADDR_W-1:0] PIN_STATUS_OFS   = 8'h6C;

    // Pull-ups on, first function, writes ignored, outputs off,
    // controller owns every line, levels low
    localparam logic [31:0] BANK_RESET [NBANK] = '{
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000};

endpackage

/* File: logic/iopm_bank_if.sv */
// Set/clear/load bundle between the controller top and one state bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface iopm_bank_if #(
    parameter int WIDTH = 32
);
    logic [WIDTH-1:0] set_bits;
    logic [WIDTH-1:0] clr_bits;
    logic [WIDTH-1:0] load_mask;
    logic [WIDTH-1:0] load_val;
    logic [WIDTH-1:0] state;

    modport ctrl (
        output set_bits,
        output clr_bits,
        output load_mask,
        output load_val,
        input  state
    );
    modport bank (
        input  set_bits,
        input  clr_bits,
        input  load_mask,
        input  load_val,
        output state
    );
endinterface
`default_nettype wire

/* File: logic/iopm_bank.sv */
// One per-line state bank: set bits, clear bits, masked direct load.
// Assumes at most one of set, clear or load is active in a cycle.
`timescale 1ns/100ps
`default_nettype none
module iopm_bank
    import iopm_pkg::*;
#(
    parameter int          WIDTH     = 32,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    iopm_bank_if.bank bus
);
    logic [WIDTH-1:0] state_q;
    logic [WIDTH-1:0] state_d;
    logic [WIDTH-1:0] after_sc;

    // Zero bits of set or clear leave the line as it was
    assign after_sc = (state_q & ~bus.clr_bits) | bus.set_bits;
    assign state_d  = (after_sc & ~bus.load_mask)
                    | (bus.load_val & bus.load_mask);
    assign bus.state = state_q;

    // New state visible one edge after the write
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= RESET_VAL[WIDTH-1:0];
        end else begin
            state_q <= state_d;
        end
    end
endmodule
`default_nettype wire

/* File: logic/iopm_ctrl.sv */
// Top of the I/O line controller: register port, line banks, pad and
// peripheral multiplexing. Assumes pads are asynchronous to i_sys_clk
// and the two peripheral functions run on i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Pull-up disable ones switch line pull-up off
// - Pull-up enable ones switch line pull-up on
// - Pull-up status reads zero when pull-up active
// - First select ones route line to first function
// - Second select ones route line to second
// - Function status: zero first, one second
// - Write enable ones let direct writes through
// - Write disable ones block direct writes
// - Write status: one means direct writes act
// - Output level bit one drives line high
// - Direct output writes obey per-line mask
module iopm_ctrl
    import iopm_pkg::*;
#(
    parameter int LINES = 32
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wr_data,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    output logic      [31:0]       o_rd_data_q,
    input  wire logic [LINES-1:0]  i_pad_in,
    output logic      [LINES-1:0]  o_pad_out_q,
    output logic      [LINES-1:0]  o_pad_oe_q,
    output logic      [LINES-1:0]  o_pullup_en_q,
    input  wire logic [LINES-1:0]  i_first_out,
    input  wire logic [LINES-1:0]  i_first_oe,
    input  wire logic [LINES-1:0]  i_second_out,
    input  wire logic [LINES-1:0]  i_second_oe,
    output logic      [LINES-1:0]  o_first_in_q,
    output logic      [LINES-1:0]  o_second_in_q
);
    iopm_bank_if #(.WIDTH(LINES)) bif [NBANK] ();

    logic [LINES-1:0] pad_meta_q;
    logic [LINES-1:0] pad_sync_q;
    logic [31:0]      rd_data_d;
    logic [LINES-1:0] pad_out_d;
    logic [LINES-1:0] pad_oe_d;
    logic [LINES-1:0] st_pullup_off;
    logic [LINES-1:0] st_second;
    logic [LINES-1:0] st_write_mask;
    logic [LINES-1:0] st_out_enable;
    logic [LINES-1:0] st_ctrl_own;
    logic [LINES-1:0] st_out_level;
    logic [LINES-1:0] wr_bits;
    // Plain copy of every bank state, so the read mux can loop over it
    logic [LINES-1:0] bank_state [NBANK];
    logic [NBANK-1:0] set_hit;
    logic [NBANK-1:0] clr_hit;
    logic [NBANK-1:0] stat_hit;
    logic             level_wr_hit;
    logic             pin_hit;

    assign wr_bits      = i_wr_data[LINES-1:0];
    assign level_wr_hit = i_wr_stb && (i_addr == OUT_LEVEL_WR_OFS);
    assign pin_hit      = (i_addr == PIN_STATUS_OFS);

    // Set and clear decode; pull-up set is the disable write and the
    // second-function set is the second select write
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        assign set_hit[b]  = i_wr_stb && (i_addr == SET_OFS[b]);
        assign clr_hit[b]  = i_wr_stb && (i_addr == CLR_OFS[b]);
        assign stat_hit[b] = (i_addr == STAT_OFS[b]);
        assign bif[b].set_bits = set_hit[b] ? wr_bits : '0;
        assign bif[b].clr_bits = clr_hit[b] ? wr_bits : '0;
        assign bank_state[b]   = bif[b].state;
        iopm_bank #(
            .WIDTH     (LINES),
            .RESET_VAL (BANK_RESET[b])
        ) u_bank (
            .i_sys_clk (i_sys_clk),
            .i_rst     (i_rst),
            .bus       (bif[b])
        );
    end

    // Only the output level bank takes direct writes, and only on lines
    // whose write mask is open
    for (genvar b = 0; b < NBANK; b++) begin : g_load
        if (b == B_OUT_LEVEL) begin : g_lvl
            assign bif[b].load_mask = level_wr_hit
                                    ? st_write_mask : '0;
            assign bif[b].load_val  = wr_bits;
        end else begin : g_none
            assign bif[b].load_mask = '0;
            assign bif[b].load_val  = '0;
        end
    end

    assign st_pullup_off = bif[B_PULLUP_OFF].state;
    assign st_second     = bif[B_SECOND_SEL].state;
    assign st_write_mask = bif[B_WRITE_MASK].state;
    assign st_out_enable = bif[B_OUT_ENABLE].state;
    assign st_ctrl_own   = bif[B_CTRL_OWN].state;
    assign st_out_level  = bif[B_OUT_LEVEL].state;

    // Read mux; write-only and unmapped addresses read as zero.
    // Status banks read raw, so pull-up reads one when off.
    always_comb begin
        rd_data_d = 32'h0000_0000;
        for (int b = 0; b < NBANK; b++) begin
            if (stat_hit[b]) begin
                rd_data_d[LINES-1:0] = bank_state[b];
            end
        end
        if (pin_hit) begin
            rd_data_d[LINES-1:0] = pad_sync_q;
        end
    end

    // Line owned by the controller drives the stored level, otherwise
    // the selected peripheral function drives it
    assign pad_out_d = (st_ctrl_own & st_out_level)
                     | (~st_ctrl_own & st_second & i_second_out)
                     | (~st_ctrl_own & ~st_second & i_first_out);
    assign pad_oe_d  = (st_ctrl_own & st_out_enable)
                     | (~st_ctrl_own & st_second & i_second_oe)
                     | (~st_ctrl_own & ~st_second & i_first_oe);

    // Pads are asynchronous; the first stage feeds only the second
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pad_meta_q <= '0;
            pad_sync_q <= '0;
        end else begin
            pad_meta_q <= i_pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // Data lands only in the cycle after the read strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_data_q <= 32'h0000_0000;
        end else begin
            o_rd_data_q <= i_rd_stb ? rd_data_d : 32'h0000_0000;
        end
    end

    // Registered pad drive adds one cycle of latency to every output
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pad_out_q   <= '0;
            o_pad_oe_q    <= '0;
            o_pullup_en_q <= '1;
        end else begin
            o_pad_out_q   <= pad_out_d;
            o_pad_oe_q    <= pad_oe_d;
            o_pullup_en_q <= ~st_pullup_off;
        end
    end

    // Peripherals see the line only while it is routed to them
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_first_in_q  <= '0;
            o_second_in_q <= '0;
        end else begin
            o_first_in_q  <= pad_sync_q & ~st_ctrl_own & ~st_second;
            o_second_in_q <= pad_sync_q & ~st_ctrl_own & st_second;
        end
    end
endmodule
`default_nettype wire

/* File: tb/iopm_monitor.sv */
// Port checker for the I/O line controller.
// Assumes it is bound into iopm_ctrl.
`timescale 1ns/100ps
`default_nettype none
module iopm_monitor
    import iopm_pkg::*;
#(
    parameter int LINES = 32
) (
    input wire logic              i_sys_clk,
    input wire logic              i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0]       i_wr_data,
    input wire logic              i_wr_stb,
    input wire logic              i_rd_stb,
    input wire logic [31:0]       o_rd_data_q,
    input wire logic [LINES-1:0]  o_pad_oe_q,
    input wire logic [LINES-1:0]  o_pullup_en_q
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    a_reset_state: assert property (disable iff (1'b0) i_rst |=>
        o_pullup_en_q == '1 && o_pad_oe_q == '0 && o_rd_data_q == '0)
        else $error("outputs not at reset values");
    a_pullup_off: assert property (
        i_wr_stb && i_addr == 8'h10 |->
        ##2 (o_pullup_en_q & $past(i_wr_data, 2)) == '0)
        else $error("pull-up still on");
    a_pullup_on: assert property (
        i_wr_stb && i_addr == 8'h14 |->
        ##2 (o_pullup_en_q & $past(i_wr_data, 2)) == $past(i_wr_data, 2))
        else $error("pull-up still off");
    a_pullup_status: assert property (
        i_rd_stb && i_addr == 8'h18 |=> o_rd_data_q == ~o_pullup_en_q)
        else $error("pull-up status not inverted");
    a_first_select: assert property (
        i_wr_stb && i_addr == 8'h1C ##1 i_rd_stb && i_addr == 8'h24 |=>
        (o_rd_data_q & $past(i_wr_data, 2)) == '0)
        else $error("line not on first function");
    a_second_select: assert property (
        i_wr_stb && i_addr == 8'h20 ##1 i_rd_stb && i_addr == 8'h24 |=>
        (o_rd_data_q & $past(i_wr_data, 2)) == $past(i_wr_data, 2))
        else $error("line not on second function");
    a_mask_open: assert property (
        i_wr_stb && i_addr == 8'h30 ##1 i_rd_stb && i_addr == 8'h38 |=>
        (o_rd_data_q & $past(i_wr_data, 2)) == $past(i_wr_data, 2))
        else $error("write mask not open");
    a_mask_closed: assert property (
        i_wr_stb && i_addr == 8'h34 ##1 i_rd_stb && i_addr == 8'h38 |=>
        (o_rd_data_q & $past(i_wr_data, 2)) == '0)
        else $error("write mask not closed");
endmodule
bind iopm_ctrl iopm_monitor #(.LINES(LINES)) u_iopm_monitor (.*);
`default_nettype wire

/* File: tb/iopm_far_model.sv */
// Stand-in for the pads and the two peripheral functions.
// Assumes one clock shared with the controller.
`timescale 1ns/100ps
`default_nettype none
module iopm_far_model #(
    parameter logic [31:0] FN_PATTERN = 32'h3C3C_3C3C
) (
    input  wire logic        i_sys_clk,
    input  wire logic [31:0] i_pad_out,
    input  wire logic [31:0] i_pad_oe,
    input  wire logic [31:0] i_pullup_en,
    output logic      [31:0] o_pad_lvl,
    output logic      [31:0] o_fn_out,
    output logic      [31:0] o_fn_oe
);
    logic [31:0] drift_q = 32'h0000_0000;
    // Undriven lines with pull-up off toggle, so no check can lean on a stale level
    always_ff @(posedge i_sys_clk) drift_q <= ~drift_q;
    assign o_pad_lvl = (i_pad_oe & i_pad_out) |
                       (~i_pad_oe & (i_pullup_en | drift_q));
    assign o_fn_out = FN_PATTERN;
    assign o_fn_oe = 32'hFFFF_FFFF;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Bench of the I/O line controller with its far-side model.
// Assumes the register map of iopm_pkg.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import iopm_pkg::*;
;
    typedef struct packed {
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [7:0]  ra;
        logic [31:0] ex;
    } iopm_row_t;
    logic              clk = 0, rst = 1, wr = 0, rd = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0]       wdat = '0, rdat, pout, poe, pup, fin, sin;
    logic [31:0]       pad, fo, foe;
    int                num_errors = 0, num_checks = 0;
    iopm_row_t         rows [16] = '{
        '{8'h00, 32'hFFFF_FFFF, 8'h18, 32'h0000_0000},
        '{8'h00, 32'h0000_0000, 8'h24, 32'h0000_0000},
        '{8'h00, 32'h0000_0000, 8'h38, 32'h0000_0000},
        '{8'h10, 32'hFFFF_FFFF, 8'h18, 32'hFFFF_FFFF},
        '{8'h14, 32'h0000_00FF, 8'h18, 32'hFFFF_FF00},
        '{8'h10, 32'h0000_0000, 8'h18, 32'hFFFF_FF00},
        '{8'h20, 32'hF0F0_0000, 8'h24, 32'hF0F0_0000},
        '{8'h1C, 32'hF000_0000, 8'h24, 32'h00F0_0000},
        '{8'h30, 32'h0000_FFFF, 8'h38, 32'h0000_FFFF},
        '{8'h34, 32'h0000_00F0, 8'h38, 32'h0000_FF0F},
        '{8'h68, 32'hAAAA_AAAA, 8'h68, 32'h0000_AA0A},
        '{8'h60, 32'h0000_0005, 8'h68, 32'h0000_AA0F},
        '{8'h64, 32'h0000_0005, 8'h68, 32'h0000_AA0A},
        '{8'h50, 32'h0000_0000, 8'h58, 32'hFFFF_FFFF},
        '{8'h44, 32'h0000_0000, 8'h48, 32'h0000_0000},
        '{8'h04, 32'h1234_5678, 8'h10, 32'h0000_0000}};
    iopm_ctrl #(.LINES(32)) u_iopm_ctrl (
        .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wdat),
        .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data_q(rdat), .i_pad_in(pad),
        .o_pad_out_q(pout), .o_pad_oe_q(poe), .o_pullup_en_q(pup),
        .i_first_out(fo), .i_first_oe(foe), .i_second_out(~fo),
        .i_second_oe(foe), .o_first_in_q(fin), .o_second_in_q(sin));
    iopm_far_model u_iopm_far_model (.i_sys_clk(clk), .i_pad_out(pout),
        .i_pad_oe(poe), .i_pullup_en(pup), .o_pad_lvl(pad), .o_fn_out(fo),
        .o_fn_oe(foe));
    initial begin
        forever #50 clk = ~clk;
    end
    // Strobes stay up between calls, so none is set twice in a step
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        #1;
    endtask
    task automatic idle(input int n);
        wr <= 0;
        rd <= 0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", s, e, g);
            num_errors++;
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        idle(2);
        rst <= 0;
        foreach (rows[k]) begin
            bus(1, rows[k].wa, rows[k].wd);
            bus(0, rows[k].ra, '0);
            chk("rd_data", rows[k].ex, rdat);
        end
        chk("pad_oe", 32'h0000_0000, poe);
        bus(1, 8'h40, 32'hFFFF_FFFF);
        idle(6);
        chk("pad_out", 32'h0000_AA0A, pout);
        chk("pad_oe", 32'hFFFF_FFFF, poe);
        chk("pullup_en", 32'h0000_00FF, pup);
        bus(0, 8'h6C, '0);
        chk("pin_status", 32'h0000_AA0A, rdat);
        idle(1);
        chk("rd_data", 32'h0000_0000, rdat);
        bus(1, 8'h54, 32'h00F0_0000);
        idle(6);
        chk("pad_out", 32'h00C0_0000, pout & 32'h00F0_0000);
        chk("second_in", 32'h00C0_0000, sin & 32'h00F0_0000);
        chk("first_in", 32'h0000_0000, fin & 32'h00F0_0000);
        bus(1, 8'h1C, 32'h0030_0000);
        bus(0, 8'h24, '0);
        chk("fn_status", 32'h00C0_0000, rdat);
        idle(6);
        chk("pad_out", 32'h00F0_0000, pout & 32'h00F0_0000);
        chk("first_in", 32'h0030_0000, fin & 32'h00F0_0000);
        chk("second_in", 32'h00C0_0000, sin & 32'h00F0_0000);
        bus(1, 8'h44, 32'h0000_000F);
        bus(0, 8'h48, '0);
        chk("oe_status", 32'hFFFF_FFF0, rdat);
        idle(6);
        chk("pad_oe", 32'hFFFF_FFF0, poe);
        bus(0, 8'h6C, '0);
        chk("pin_status", 32'h0000_000F, rdat & 32'h0000_000F);
        rst <= 1;
        idle(2);
        rst <= 0;
        bus(0, 8'h18, '0);
        chk("pullup_status", 32'h0000_0000, rdat);
        chk("pullup_en", 32'hFFFF_FFFF, pup);
        chk("pad_oe", 32'h0000_0000, poe);
        finish_test();
    end
endmodule
`default_nettype wire
